// ### hw/glur_defines.vh
`ifndef GLUR_DEFINES_VH
`define GLUR_DEFINES_VH

// system clock
`define GLUR_CLK_HZ          40000000

// serial line format: 8 data bits, 1 stop bit, no parity
`define GLUR_BAUD            4800
`define GLUR_DATA_BITS       8
`define GLUR_BIT_CYCLES      (`GLUR_CLK_HZ / `GLUR_BAUD)

// report interval, in milliseconds, and its length in clock cycles
`define GLUR_REPORT_MS       1000
`define GLUR_REPORT_CYCLES   ((`GLUR_CLK_HZ / 1000) * `GLUR_REPORT_MS)

// warm-up time in minutes, counted in report ticks
`define GLUR_WARMUP_MIN      3
`define GLUR_WARMUP_TICKS    ((`GLUR_WARMUP_MIN * 60 * 1000) / `GLUR_REPORT_MS)

// frame layout
`define GLUR_FRAME_HDR       8'hAA
`define GLUR_FRAME_BYTES     3'h4
`define GLUR_IDX_HDR         2'h0
`define GLUR_IDX_STATUS      2'h1
`define GLUR_IDX_CONC        2'h2
`define GLUR_IDX_SUM         2'h3

// checksum of the reset frame contents (warm-up status, zero level), carry dropped
`define GLUR_SUM_RST         8'h2C

// status codes
`define GLUR_ST_OK           8'h80
`define GLUR_ST_FAULT        8'h81
`define GLUR_ST_WARMUP       8'h82

// concentration values
`define GLUR_CONC_ZERO       8'h00
`define GLUR_CONC_MAX        8'h64
`define GLUR_CONC_OVER       8'hFF

// byte buffer between frame builder and transmitter
`define GLUR_FIFO_WIDTH      8
`define GLUR_FIFO_DEPTH      8

`endif

// ### hw/glur_fifo.v
`timescale 1ns/1ps
`default_nettype none

module glur_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire             clock_i,
    input  wire             rst_i,
    // fill side
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    // drain side
    output wire [WIDTH-1:0] out_data_o,
    output wire             out_valid_o,
    input  wire             out_ready_i
);

    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_q;
    reg [AW-1:0]    rd_ptr_q;
    reg [AW:0]      count_q;
    wire            push;
    wire            pop;

    // full and empty come from the occupancy count, not pointer compare
    assign in_ready_o  = (count_q != DEPTH[AW:0]);
    assign out_valid_o = (count_q != {(AW+1){1'b0}});
    assign out_data_o  = mem_q[rd_ptr_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // storage has no reset; only written words are ever read
    always @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    // pointers and occupancy
    always @(posedge clock_i) begin
        if (rst_i) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push & ~pop) begin
                count_q <= count_q + {{AW{1'b0}}, 1'b1};
            end else if (pop & ~push) begin
                count_q <= count_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end

endmodule // glur_fifo

`default_nettype wire

// ### hw/glur_uart_tx.v
`timescale 1ns/1ps
`default_nettype none
`include "glur_defines.vh"

module glur_uart_tx #(
    parameter BIT_CYCLES = `GLUR_BIT_CYCLES
) (
    // clock and reset
    input  wire       clock_i,
    input  wire       rst_i,
    // byte to send
    input  wire [7:0] data_i,
    input  wire       valid_i,
    output wire       ready_o,
    // serial line
    output wire       txd_o,
    output wire       done_o
);

    reg        busy_q;
    reg        txd_q;
    reg        done_q;
    reg [9:0]  shift_q;
    reg [3:0]  bits_q;
    reg [13:0] div_q;
    wire       bit_en;

    assign ready_o = ~busy_q;
    assign txd_o   = txd_q;
    assign done_o  = done_q;
    // one-cycle enable at the bit rate; truncation keeps the bit slightly short
    assign bit_en  = busy_q && ({18'h00000, div_q} == BIT_CYCLES - 1);

    // bit-rate divider, restarted with every byte
    always @(posedge clock_i) begin
        if (rst_i || !busy_q || bit_en) begin
            div_q <= 14'h0000;
        end else begin
            div_q <= div_q + 14'h0001;
        end
    end

    // 8N1 shifter: start bit, lsb first, one stop bit
    always @(posedge clock_i) begin
        if (rst_i) begin
            busy_q  <= 1'b0;
            txd_q   <= 1'b1;
            done_q  <= 1'b0;
            shift_q <= 10'h3FF;
            bits_q  <= 4'h0;
        end else begin
            done_q <= 1'b0;
            if (!busy_q) begin
                if (valid_i) begin
                    busy_q  <= 1'b1;
                    shift_q <= {1'b1, data_i, 1'b0};
                    bits_q  <= 4'hA;
                    txd_q   <= 1'b0;
                end
            end else if (bit_en) begin
                if (bits_q == 4'h1) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    txd_q  <= 1'b1;
                end else begin
                    shift_q <= {1'b1, shift_q[9:1]};
                    txd_q   <= shift_q[1];
                end
                bits_q <= bits_q - 4'h1;
            end
        end
    end

endmodule // glur_uart_tx

`default_nettype wire

// ### hw/glur_reporter.v
`timescale 1ns/1ps
`default_nettype none
`include "glur_defines.vh"

module glur_reporter #(
    parameter REPORT_CYCLES = `GLUR_REPORT_CYCLES,
    parameter BIT_CYCLES    = `GLUR_BIT_CYCLES,
    parameter WARMUP_TICKS  = `GLUR_WARMUP_TICKS
) (
    // clock and reset
    input  wire        clock_i,
    input  wire        rst_i,
    // measurement from the sensing front end
    input  wire [7:0]  level_i,
    input  wire        over_range_i,
    input  wire        fault_i,
    // serial output toward the host receiver
    output wire        txd_o,
    // report state
    output wire        warmup_o,
    output wire [7:0]  status_o,
    output wire [7:0]  conc_o,
    output wire [7:0]  checksum_o,
    // frame events
    output wire        frame_start_o,
    output wire        frame_done_o,
    output wire        frame_skip_o,
    output wire [15:0] frame_count_o,
    output wire        busy_o
);

    // frame sequencer states
    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_BUILD = 3'h1;
    localparam [2:0] S_PUSH  = 3'h2;
    localparam [2:0] S_DRAIN = 3'h3;
    localparam [2:0] S_DONE  = 3'h4;

    // sequencer
    reg  [2:0]  state_q;
    reg  [2:0]  state_d;

    // report tick and warm-up timing
    reg  [25:0] tick_cnt_q;
    reg         tick_q;
    wire        tick_wrap;
    reg  [7:0]  warm_cnt_q;
    reg         warmup_q;

    // frame contents, frozen at the build step
    reg  [7:0]  status_q;
    reg  [7:0]  conc_q;
    reg  [7:0]  sum_q;
    reg  [7:0]  status_d;
    reg  [7:0]  conc_d;
    wire [9:0]  sum_full;

    // frame builder
    reg  [1:0]  idx_q;
    reg  [7:0]  push_data;
    wire        push_valid;
    wire        push_ready;
    wire        push_last;

    // event outputs
    reg         start_q;
    reg         done_q;
    reg         skip_q;
    reg  [15:0] count_q;
    reg         busy_q;

    // buffer to line driver
    wire [7:0]  fifo_data;
    wire        fifo_valid;
    wire        tx_ready;

    // one-second divider; fires on the first cycle after reset as well
    assign tick_wrap = ({6'h00, tick_cnt_q} == REPORT_CYCLES - 1);

    // tick is preset in reset, so no one waits a full second for the first frame
    always @(posedge clock_i) begin
        if (rst_i) begin
            tick_cnt_q <= 26'h0000000;
            tick_q     <= 1'b1;
        end else if (tick_wrap) begin
            tick_cnt_q <= 26'h0000000;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 26'h0000001;
            tick_q     <= 1'b0;
        end
    end

    // warm-up counted in report ticks so the counter stays narrow
    always @(posedge clock_i) begin
        if (rst_i) begin
            warm_cnt_q <= 8'h00;
            warmup_q   <= 1'b1;
        end else if (tick_q && warmup_q) begin
            // the reset tick is counted too, so this tick closes the last warm-up second
            if ({24'h000000, warm_cnt_q} == WARMUP_TICKS) begin
                warmup_q <= 1'b0;
            end
            // counting stops with warm-up, so the counter cannot wrap
            warm_cnt_q <= warm_cnt_q + 8'h01;
        end
    end

    // status code: warm-up outranks a fault, since readings are not yet trusted
    always @* begin
        status_d = `GLUR_ST_OK;
        if (warmup_q) begin
            status_d = `GLUR_ST_WARMUP;
        end else if (fault_i) begin
            status_d = `GLUR_ST_FAULT;
        end
    end

    // concentration: zero in warm-up, clamp anything past full scale to over-range
    always @* begin
        conc_d = level_i;
        if (warmup_q) begin
            conc_d = `GLUR_CONC_ZERO;
        end else if (over_range_i || (level_i > `GLUR_CONC_MAX)) begin
            conc_d = `GLUR_CONC_OVER;
        end
    end

    // additive checksum on the values about to be latched
    assign sum_full = {2'b00, `GLUR_FRAME_HDR} + {2'b00, status_d} + {2'b00, conc_d};

    // byte selector for the frame builder
    always @* begin
        case (idx_q)
            `GLUR_IDX_HDR:    push_data = `GLUR_FRAME_HDR;
            `GLUR_IDX_STATUS: push_data = status_q;
            `GLUR_IDX_CONC:   push_data = conc_q;
            `GLUR_IDX_SUM:    push_data = sum_q;
            default:          push_data = `GLUR_FRAME_HDR;
        endcase
    end

    assign push_valid = (state_q == S_PUSH);
    assign push_last  = ({1'b0, idx_q} == (`GLUR_FRAME_BYTES - 3'h1));

    // sequencer: latch, push four bytes, wait until the line is quiet
    always @* begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                // wait for the report tick
                if (tick_q) begin
                    state_d = S_BUILD;
                end
            end
            S_BUILD: begin
                // inputs are sampled into the frame on this cycle
                state_d = S_PUSH;
            end
            S_PUSH: begin
                // a full buffer stalls the builder here
                if (push_ready && push_last) begin
                    state_d = S_DRAIN;
                end
            end
            S_DRAIN: begin
                // buffer empty and the last stop bit finished
                if (!fifo_valid && tx_ready) begin
                    state_d = S_DONE;
                end
            end
            S_DONE: begin
                // one cycle for the done pulse and the count
                state_d = S_IDLE;
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    // sequencer state register
    always @(posedge clock_i) begin
        if (rst_i) begin
            state_q <= S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // frame contents are frozen at the build step so all four bytes agree
    always @(posedge clock_i) begin
        if (rst_i) begin
            status_q <= `GLUR_ST_WARMUP;
            conc_q   <= `GLUR_CONC_ZERO;
            sum_q    <= `GLUR_SUM_RST;
        end else if (state_q == S_BUILD) begin
            status_q <= status_d;
            conc_q   <= conc_d;
            sum_q    <= sum_full[7:0];
        end
    end

    // byte index walks header to checksum
    always @(posedge clock_i) begin
        if (rst_i) begin
            idx_q <= `GLUR_IDX_HDR;
        end else if (state_q == S_BUILD) begin
            // every frame restarts at the header
            idx_q <= `GLUR_IDX_HDR;
        end else if (push_valid && push_ready) begin
            idx_q <= idx_q + 2'h1;
        end
    end

    // one-cycle event pulses, one clock behind the sequencer
    always @(posedge clock_i) begin
        if (rst_i) begin
            start_q <= 1'b0;
            done_q  <= 1'b0;
            skip_q  <= 1'b0;
        end else begin
            start_q <= (state_q == S_BUILD);
            done_q  <= (state_q == S_DONE);
            // a tick while a frame is still out is dropped, not queued
            skip_q  <= tick_q && (state_q != S_IDLE);
        end
    end

    // busy looks at the next state so it rises with the build step
    always @(posedge clock_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_d != S_IDLE);
        end
    end

    // completed frames; wraps silently, the host never sees this count
    always @(posedge clock_i) begin
        if (rst_i) begin
            count_q <= 16'h0000;
        end else if (state_q == S_DONE) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // byte buffer between builder and line driver
    // eight words hold two whole frames, so the builder never stalls in practice
    glur_fifo #(
        .WIDTH (`GLUR_FIFO_WIDTH),
        .DEPTH (`GLUR_FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .in_data_i   (push_data),
        .in_valid_i  (push_valid),
        .in_ready_o  (push_ready),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (tx_ready)
    );

    // serial line driver; only the output direction exists here
    glur_uart_tx #(
        .BIT_CYCLES (BIT_CYCLES)
    ) u_tx (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .data_i  (fifo_data),
        .valid_i (fifo_valid),
        .ready_o (tx_ready),
        .txd_o   (txd_o),
        .done_o  ()
    );

    // outputs straight from flops
    assign warmup_o      = warmup_q;
    assign status_o      = status_q;
    assign conc_o        = conc_q;
    assign checksum_o    = sum_q;
    assign frame_start_o = start_q;
    assign frame_done_o  = done_q;
    assign frame_skip_o  = skip_q;
    assign frame_count_o = count_q;
    assign busy_o        = busy_q;

endmodule // glur_reporter

`default_nettype wire

// ### tb/glur_host_rx.sv
`timescale 1ns/1ps
`default_nettype none
// host receiver: takes the reporter serial output on its own receive input
module glur_host_rx #(
    parameter BIT_CYCLES = 4
) (
    input  wire logic       clock_i,
    input  wire logic       rxd_i,
    output var  logic [7:0] byte_o,
    output var  logic       stb_o,
    output var  logic       frm_err_o
);
    initial begin
        byte_o    = 8'h00;
        stb_o     = 1'b0;
        frm_err_o = 1'b0;
    end
    // 8n1, lsb first, sampled mid-bit on the falling clock to stay off the launch edge
    always begin : rx_loop
        integer i;
        @(negedge rxd_i);
        repeat (BIT_CYCLES / 2) @(negedge clock_i);
        for (i = 0; i < 8; i = i + 1) begin
            repeat (BIT_CYCLES) @(negedge clock_i);
            byte_o[i] = rxd_i;
        end
        repeat (BIT_CYCLES) @(negedge clock_i);
        frm_err_o = !rxd_i; // stop bit must be high
        @(posedge clock_i) stb_o = 1'b1;
        @(posedge clock_i) stb_o = 1'b0;
    end
endmodule // glur_host_rx
`default_nettype wire

// ### tb/glur_reporter_properties.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the reporter, written for a bit time of four clocks
module glur_reporter_properties #(
    parameter REPORT_CYCLES = 2000
) (
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic        txd_o,
    input wire logic        warmup_o,
    input wire logic [7:0]  status_o,
    input wire logic [7:0]  conc_o,
    input wire logic [7:0]  checksum_o,
    input wire logic        frame_start_o,
    input wire logic        frame_done_o,
    input wire logic        frame_skip_o,
    input wire logic [15:0] frame_count_o,
    input wire logic        busy_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic [31:0] gap_q;
    logic        seen_q;
    // cycles since the last frame start; the first start after reset has no predecessor
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            gap_q  <= 32'h0;
            seen_q <= 1'b0;
        end else if (frame_start_o) begin
            gap_q  <= 32'h0;
            seen_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 32'h1;
        end
    end
    // start bit stays low for at least three clocks after it falls
    sequence start_low_s;
        !txd_o [*3];
    endsequence
    sequence count_step_s;
        frame_count_o == $past(frame_count_o) + 16'h1;
    endsequence
    status_code_a: assert property (status_o inside {8'h80, 8'h81, 8'h82})
        else $error("status code outside the legal set");
    warm_status_a: assert property (frame_start_o |-> (status_o == 8'h82) == warmup_o)
        else $error("warm-up status does not follow warm-up state");
    warm_zero_a: assert property (frame_start_o && warmup_o |-> conc_o == 8'h00)
        else $error("nonzero level during warm-up");
    conc_range_a: assert property (frame_start_o |-> conc_o <= 8'h64 || conc_o == 8'hFF)
        else $error("level byte out of range");
    check_sum_a: assert property (frame_start_o |-> checksum_o == 8'(8'hAA + status_o + conc_o))
        else $error("checksum wrong");
    line_idle_a: assert property (!busy_o |-> txd_o)
        else $error("line not idle high between frames");
    start_bit_a: assert property ($fell(txd_o) |-> start_low_s)
        else $error("start bit too short");
    frame_done_a: assert property (frame_done_o |-> !busy_o ##0 count_step_s)
        else $error("frame end does not count");
    report_gap_a: assert property (frame_start_o && seen_q |-> gap_q == REPORT_CYCLES - 1)
        else $error("report interval wrong");
    no_skip_a: assert property (!frame_skip_o)
        else $error("report tick dropped");
endmodule // glur_reporter_properties
bind glur_reporter glur_reporter_properties #(.REPORT_CYCLES(REPORT_CYCLES)) chk (
    .clock_i(clock_i), .rst_i(rst_i), .txd_o(txd_o), .warmup_o(warmup_o),
    .status_o(status_o), .conc_o(conc_o), .checksum_o(checksum_o),
    .frame_start_o(frame_start_o), .frame_done_o(frame_done_o),
    .frame_skip_o(frame_skip_o), .frame_count_o(frame_count_o), .busy_o(busy_o));
`default_nettype wire

// ### tb/glur_reporter_bench.sv
`timescale 1ns/1ps
`default_nettype none
// compare one value against its expectation
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", nm, e, a); end end
module glur_reporter_bench;
    localparam int RPT  = 2000;
    localparam int BITC = 4;
    logic        clock_i      = 1'b0;
    logic        rst_i        = 1'b1;
    logic [7:0]  level_i      = 8'h32;
    logic        over_range_i = 1'b0;
    logic        fault_i      = 1'b1;
    wire         txd_o, warmup_o, frame_start_o, frame_done_o, frame_skip_o, busy_o;
    wire  [7:0]  status_o, conc_o, checksum_o, rx_byte;
    wire  [15:0] frame_count_o;
    wire         rx_stb, rx_err;
    int          error_cnt    = 0;
    int          num_checks   = 0;
    logic [7:0]  rx [0:3];
    logic [15:0] frames       = 16'h0;

    // short counts keep a frame well inside one report period
    glur_reporter #(.REPORT_CYCLES(RPT), .BIT_CYCLES(BITC), .WARMUP_TICKS(3)) uut (
        .clock_i(clock_i), .rst_i(rst_i), .level_i(level_i),
        .over_range_i(over_range_i), .fault_i(fault_i), .txd_o(txd_o),
        .warmup_o(warmup_o), .status_o(status_o), .conc_o(conc_o),
        .checksum_o(checksum_o), .frame_start_o(frame_start_o),
        .frame_done_o(frame_done_o), .frame_skip_o(frame_skip_o),
        .frame_count_o(frame_count_o), .busy_o(busy_o));
    glur_host_rx #(.BIT_CYCLES(BITC)) host (
        .clock_i(clock_i), .rxd_i(txd_o), .byte_o(rx_byte), .stb_o(rx_stb),
        .frm_err_o(rx_err));

    // 40 mhz clock
    always #12.5 clock_i = ~clock_i;

    task close_out;
        if (error_cnt == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // sets the inputs for the next build, then takes and judges one whole frame
    task frame(input [7:0] lv, input ov, input ft, input [7:0] st, input [7:0] cn);
        int k;
        int n;
        logic [7:0] sm;
        level_i = lv;
        over_range_i = ov;
        fault_i = ft;
        sm = 8'hAA + st + cn; // carry dropped
        for (k = 0; k < 4; k++) begin
            n = 0;
            while (rx_stb !== 1'b1 && n < 3000) begin
                @(negedge clock_i);
                n++;
            end
            `CHK("rx wait", 1'b1, n < 3000)
            rx[k] = rx_byte;
            `CHK("stop", 1'b0, rx_err)
            @(negedge clock_i);
        end
        `CHK("header", 8'hAA, rx[0])
        `CHK("status", st, rx[1])
        `CHK("level", cn, rx[2])
        `CHK("sum", sm, rx[3])
        `CHK("status_o", st, status_o)
        `CHK("checksum_o", sm, checksum_o)
        `CHK("conc_o", cn, conc_o)
        `CHK("over", st != 8'h82 && (ov || lv > 8'h64), rx[2] == 8'hFF)
        // the count moves with the done pulse, a few clocks after the last stop bit
        `CHK("count", frames, frame_count_o)
        n = 0;
        while (frame_done_o !== 1'b1 && n < 50) begin
            @(negedge clock_i);
            n++;
        end
        `CHK("done", 1'b1, frame_done_o)
        `CHK("count done", frames + 16'h1, frame_count_o)
        frames++;
    endtask

    // fault held during warm-up must not show
    task t_warmup;
        repeat (3) frame(8'h32, 1'b0, 1'b1, 8'h82, 8'h00);
        `CHK("warmup_o", 1'b1, warmup_o)
    endtask

    task t_codes;
        frame(8'h32, 1'b0, 1'b0, 8'h80, 8'h32);
        `CHK("warmup_o", 1'b0, warmup_o)
        frame(8'h32, 1'b0, 1'b1, 8'h81, 8'h32);
    endtask

    // edges of the level range, the over-range flag, and a sum that carries
    task t_range;
        frame(8'h64, 1'b0, 1'b0, 8'h80, 8'h64);
        frame(8'h65, 1'b0, 1'b0, 8'h80, 8'hFF);
        frame(8'h0A, 1'b1, 1'b0, 8'h80, 8'hFF);
        frame(8'h00, 1'b0, 1'b0, 8'h80, 8'h00);
    endtask

    // second reset mid-run restarts warm-up and the frame count
    task t_reset;
        rst_i = 1'b1;
        repeat (5) @(negedge clock_i);
        `CHK("rst status", 8'h82, status_o)
        `CHK("rst warmup", 1'b1, warmup_o)
        `CHK("rst conc", 8'h00, conc_o)
        `CHK("rst line", 1'b1, txd_o)
        `CHK("rst sum", 8'h2C, checksum_o)
        `CHK("rst count", 16'h0, frame_count_o)
        rst_i = 1'b0;
        frames = 16'h0;
        frame(8'h32, 1'b0, 1'b0, 8'h82, 8'h00);
    endtask

    // watchdog: about eight report periods are needed, twenty are allowed
    initial begin
        repeat (40000) @(posedge clock_i);
        error_cnt++;
        close_out();
    end

    // main sequence
    initial begin
        repeat (5) @(negedge clock_i);
        rst_i = 1'b0;
        t_warmup();
        t_codes();
        t_range();
        t_reset();
        close_out();
    end
endmodule // glur_reporter_bench
`default_nettype wire
